// file: rotate_and_sleep_pkg.sv
package rotate_and_sleep_pkg;

   // ==========================================
   // instruction encodings
   // ==========================================
   // upper six bits of the rotate-left opcode
   localparam logic [5:0] ROT_OPCODE = 6'h0D;
   // full sleep opcode
   localparam logic [13:0] SLEEP_WORD = 14'h0063;
   // destination bit position
   localparam int DEST_BIT = 7;

   // ==========================================
   // register map (byte addresses)
   // ==========================================
   // file registers occupy 00h..7Fh
   localparam logic [7:0] FILE_LAST = 8'h7F;
   localparam logic [7:0] ACC_ADDR = 8'h80;
   localparam logic [7:0] STATUS_ADDR = 8'h81;
   localparam logic [7:0] WDOG_ADDR = 8'h82;
   localparam logic [7:0] PRESC_ADDR = 8'h83;
   localparam logic [7:0] CTRL_ADDR = 8'h84;

   // ==========================================
   // field positions
   // ==========================================
   localparam int CARRY_POS = 0;
   localparam int PD_POS = 3;
   localparam int TO_POS = 4;
   localparam int WDOG_EN_POS = 0;

   // ==========================================
   // reset values
   // ==========================================
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic CARRY_RST = 1'b0;
   localparam logic PD_RST = 1'b1;
   localparam logic TO_RST = 1'b1;
   localparam logic WDOG_EN_RST = 1'b0;
   localparam logic [7:0] CNT_RST = 8'h00;

   // ==========================================
   // types
   // ==========================================
   // one instruction offered by the fetch stage
   typedef struct packed {
      logic valid;
      logic [13:0] word;
   } instr_s;

   // core run state, one-hot
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_SLEEP = 2'b10
   } core_state_e;

endpackage : rotate_and_sleep_pkg

// file: rotate_and_sleep_exec.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rotate_and_sleep_exec #(
   // prescaler terminal count for watchdog ticks
   parameter logic [7:0] PRESC_MAX = 8'hFF
) (
   // core clock, 50 MHz
   input wire logic ref_clk,
   // asynchronous reset, active high
   input wire logic sys_rst,
   // freezes all state while low
   input wire logic clk_en,
   // instruction offered by fetch
   input wire rotate_and_sleep_pkg::instr_s instr,
   // fetch may offer an instruction
   output logic instr_ready,
   // one-cycle pulse: instruction executed
   output logic exec_done,
   // one-cycle pulse: word was not ours
   output logic exec_other,
   // level: core sleeping
   output logic sleeping,
   // level: oscillator running
   output logic osc_enable,
   // wake-up request from outside
   input wire logic wake_req,
   // one-cycle pulse: watchdog expired
   output logic wdog_expired,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   import rotate_and_sleep_pkg::*;

   // ==========================================
   // decode functions
   // ==========================================

   function automatic logic is_rotate(input logic [13:0] w);
      is_rotate = (w[13:8] == ROT_OPCODE);
   endfunction : is_rotate

   // exact match on the sleep word
   function automatic logic is_sleep(input logic [13:0] w);
      is_sleep = (w == SLEEP_WORD);
   endfunction : is_sleep

   // file register window of the bus map
   function automatic logic is_file(input logic [7:0] a);
      is_file = (a <= FILE_LAST);
   endfunction : is_file

   // ==========================================
   // state
   // ==========================================

   // 128-byte file register space
   logic [7:0] file_mem [0:127];
   // working accumulator
   logic [7:0] acc;
   // status bits
   logic carry;
   logic power_down_flag;
   logic timeout_flag;
   // watchdog enable from control register
   logic wdog_en;
   // watchdog prescaler and counter
   logic [7:0] presc;
   logic [7:0] watchdog_counter;
   // run / sleep state
   core_state_e state;
   core_state_e next_state;

   // ==========================================
   // execution decode
   // ==========================================

   // an instruction is taken only while running
   logic take;
   // decoded rotate and sleep this cycle
   logic do_rot;
   logic do_sleep;
   // operand address and destination
   logic [6:0] f_addr;
   logic dest_file;
   // operand, result and carry out
   logic [7:0] src;
   logic [7:0] rot_res;
   logic rot_carry;
   // watchdog tick and overflow
   logic presc_tick;
   logic wdog_ovf;

   // fetch is only accepted while the clock runs
   assign instr_ready = (state == ST_RUN);
   assign take = instr.valid & instr_ready & clk_en;

   assign do_rot = take & is_rotate(instr.word);
   assign do_sleep = take & is_sleep(instr.word);
   assign f_addr = instr.word[6:0];
   assign dest_file = instr.word[DEST_BIT];

   // combinational read of the operand
   assign src = file_mem[f_addr];

   assign rot_res = {src[6:0], carry};
   assign rot_carry = src[7];

   // oscillator follows the run state
   assign sleeping = (state == ST_SLEEP);
   assign osc_enable = (state == ST_RUN);

   // watchdog advances on a prescaler wrap
   assign presc_tick = wdog_en & (presc == PRESC_MAX);
   assign wdog_ovf = presc_tick & (watchdog_counter == 8'hFF);

   // ==========================================
   // run / sleep state machine
   // ==========================================

   // sleep is left by a wake request or expiry
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (do_sleep) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // either wake source restarts the core
            if (wake_req | wdog_ovf) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            // illegal code recovers to run
            next_state = ST_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_RUN;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // ==========================================
   // file register array
   // ==========================================

   // no reset on the array: it is plain RAM.
   // the instruction write lands after the bus
   // write, so the core wins a same-cycle clash
   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         if (reg_wr & is_file(reg_addr)) begin
            file_mem[reg_addr[6:0]] <= reg_wdata;
         end
         if (do_rot & dest_file) begin
            file_mem[f_addr] <= rot_res;
         end
      end
   end

   // ==========================================
   // accumulator
   // ==========================================

   // rotate to acc checked first, so it overrides a bus write
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc <= ACC_RST;
      end else if (clk_en) begin
         if (do_rot & ~dest_file) begin
            acc <= rot_res;
         end else if (reg_wr & (reg_addr == ACC_ADDR)) begin
            acc <= reg_wdata;
         end
      end
   end

   // ==========================================
   // status flags
   // ==========================================

   // carry: the rotate wins over a status write
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         carry <= CARRY_RST;
      end else if (clk_en) begin
         if (do_rot) begin
            carry <= rot_carry;
         end else if (reg_wr & (reg_addr == STATUS_ADDR)) begin
            carry <= reg_wdata[CARRY_POS];
         end
      end
   end

   // power-down flag: software may write it,
   // but a sleep in the same cycle wins
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_down_flag <= PD_RST;
      end else if (clk_en) begin
         if (do_sleep) begin
            power_down_flag <= 1'b0;
         end else if (reg_wr & (reg_addr == STATUS_ADDR)) begin
            power_down_flag <= reg_wdata[PD_POS];
         end
      end
   end

   // time-out flag: a sleep sets it even if the watchdog
   // expires in that cycle; expiry beats a software write
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_flag <= TO_RST;
      end else if (clk_en) begin
         if (do_sleep) begin
            timeout_flag <= 1'b1;
         end else if (wdog_ovf) begin
            timeout_flag <= 1'b0;
         end else if (reg_wr & (reg_addr == STATUS_ADDR)) begin
            timeout_flag <= reg_wdata[TO_POS];
         end
      end
   end

   // ==========================================
   // control register
   // ==========================================

   // watchdog enable, software owned
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdog_en <= WDOG_EN_RST;
      end else if (clk_en) begin
         if (reg_wr & (reg_addr == CTRL_ADDR)) begin
            wdog_en <= reg_wdata[WDOG_EN_POS];
         end
      end
   end

   // ==========================================
   // watchdog
   // ==========================================

   // prescaler keeps counting in sleep, so the
   // watchdog can still end a hung sleep
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc <= CNT_RST;
      end else if (clk_en) begin
         if (do_sleep) begin
            presc <= CNT_RST;
         end else if (presc_tick) begin
            presc <= CNT_RST;
         end else if (wdog_en) begin
            presc <= presc + 8'h01;
         end
      end
   end

   // counter wraps to zero on overflow
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_counter <= CNT_RST;
      end else if (clk_en) begin
         if (do_sleep) begin
            watchdog_counter <= CNT_RST;
         end else if (presc_tick) begin
            watchdog_counter <= watchdog_counter + 8'h01;
         end
      end
   end

   // ==========================================
   // completion pulses
   // ==========================================

   // one pulse per accepted word, a cycle later
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         exec_done <= 1'b0;
         exec_other <= 1'b0;
         wdog_expired <= 1'b0;
      end else if (clk_en) begin
         exec_done <= do_rot | do_sleep;
         exec_other <= take & ~(do_rot | do_sleep);
         wdog_expired <= wdog_ovf;
      end
   end

   // ==========================================
   // register read port
   // ==========================================

   // data valid only in the cycle after the
   // strobe; zero elsewhere and when unmapped
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            if (is_file(reg_addr)) begin
               reg_rdata <= file_mem[reg_addr[6:0]];
            end else begin
               unique case (reg_addr)
                  ACC_ADDR: begin
                     reg_rdata <= acc;
                  end
                  STATUS_ADDR: begin
                     reg_rdata[CARRY_POS] <= carry;
                     reg_rdata[PD_POS] <= power_down_flag;
                     reg_rdata[TO_POS] <= timeout_flag;
                  end
                  WDOG_ADDR: begin
                     reg_rdata <= watchdog_counter;
                  end
                  PRESC_ADDR: begin
                     reg_rdata <= presc;
                  end
                  CTRL_ADDR: begin
                     reg_rdata[WDOG_EN_POS] <= wdog_en;
                  end
                  default: begin
                     // unmapped reads as zero
                     reg_rdata <= 8'h00;
                  end
               endcase
            end
         end
      end
   end

endmodule : rotate_and_sleep_exec

`default_nettype wire

// file: rotate_and_sleep_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the rotate and sleep block
// ==========================================
module rotate_and_sleep_chk (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire rotate_and_sleep_pkg::instr_s instr,
   input wire logic instr_ready,
   input wire logic exec_done,
   input wire logic exec_other,
   input wire logic sleeping,
   input wire logic osc_enable,
   input wire logic wdog_expired,
   input wire logic wake_req,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   import rotate_and_sleep_pkg::*;
   // word accepted at this edge
   wire logic take = clk_en && instr.valid && instr_ready;
   wire logic is_rot = instr.word[13:8] == ROT_OPCODE;
   wire logic is_slp = instr.word == SLEEP_WORD;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_done; take && (is_rot || is_slp) |=> exec_done && !exec_other; endproperty
   a_done: assert property (p_done) else $error("no done pulse");
   property p_other; take && !is_rot && !is_slp |=> exec_other && !exec_done; endproperty
   a_other: assert property (p_other) else $error("foreign word not flagged");
   property p_idle; clk_en && !take |=> !exec_done && !exec_other; endproperty
   a_idle: assert property (p_idle) else $error("pulse without a word");
   property p_enter; take && is_slp |=> sleeping && !osc_enable; endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered");
   property p_halt; sleeping |-> !instr_ready && !osc_enable; endproperty
   a_halt: assert property (p_halt) else $error("core runs while asleep");
   property p_wake; sleeping && clk_en && wake_req |=> !sleeping; endproperty
   a_wake: assert property (p_wake) else $error("wake ignored");
   // the idle cycle keeps a bus write from overriding the flags
   property p_flags;
      (take && is_slp) ##1 !reg_wr ##1 (clk_en && reg_rd && reg_addr == STATUS_ADDR)
      |=> reg_rdata[PD_POS] == 1'b0 && reg_rdata[TO_POS] == 1'b1;
   endproperty
   a_flags: assert property (p_flags) else $error("sleep flags wrong");
   property p_wdog;
      (take && is_slp) ##1 !reg_wr ##1 (clk_en && reg_rd && reg_addr == WDOG_ADDR)
      |=> reg_rdata == 8'h00;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
   c_rot: cover property (take && is_rot);
   c_slp: cover property (take && is_slp);
   c_wake: cover property (sleeping ##1 !sleeping);
   c_expire: cover property (wdog_expired);
endmodule : rotate_and_sleep_chk
bind rotate_and_sleep_exec rotate_and_sleep_chk chk_u (.ref_clk, .sys_rst, .clk_en, .instr,
   .instr_ready, .exec_done, .exec_other, .sleeping, .osc_enable, .wdog_expired, .wake_req,
   .reg_addr,
   .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import rotate_and_sleep_pkg::*;
   logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, wake_req = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, tk_d = 1'b0, c;
   logic power_down_flag, timeout_flag, instr_ready, exec_done, exec_other;
   logic sleeping, osc_enable, wdog_expired;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, acc, v, res, e;
   logic [6:0] f;
   instr_s instr = '0;
   logic [7:0] q[$];
   int failures = 0, num_checks = 0, cyc = 0;
   // ==========================================
   // clock and design
   // ==========================================
   always #10 ref_clk = ~ref_clk;
   // short prescaler keeps the watchdog scenario brief
   rotate_and_sleep_exec #(.PRESC_MAX(8'h03)) dut_u (.ref_clk, .sys_rst, .clk_en, .instr,
      .instr_ready, .exec_done, .exec_other, .sleeping, .osc_enable, .wake_req,
      .wdog_expired, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   // ==========================================
   // drivers: rd and ex note their expectation first
   // ==========================================
   function automatic logic [7:0] st();
      return {3'b000, timeout_flag, power_down_flag, 2'b00, c};
   endfunction : st
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      q.push_back(x);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask : rd
   // code is {done, other, sleeping}; a refused word notes nothing
   task automatic ex(input logic [13:0] w, input logic [7:0] x, input logic tk);
      if (tk) q.push_back(x);
      @(posedge ref_clk);
      instr <= {1'b1, w};
      @(posedge ref_clk);
      instr.valid <= 1'b0;
   endtask : ex
   task automatic wake();
      @(posedge ref_clk);
      wake_req <= 1'b1;
      @(posedge ref_clk);
      wake_req <= 1'b0;
   endtask : wake
   task automatic conclude();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   // ==========================================
   // monitor: results are taken off in order
   // ==========================================
   always @(posedge ref_clk) begin
      rd_d <= reg_rd;
      tk_d <= instr.valid && instr_ready;
      cyc <= cyc + 1;
      // a hang counts as a failure
      if (cyc == 2000) begin
         failures++;
         conclude();
      end
   end
   always @(negedge ref_clk) begin
      if (rd_d) begin
         e = q.pop_front();
         `CHK(reg_rdata, e)
      end
      if (tk_d) begin
         e = q.pop_front();
         `CHK({5'h00, exec_done, exec_other, sleeping}, e)
      end
      // an expiry must also end the sleep
      if (wdog_expired) begin
         e = q.pop_front();
         `CHK({7'h00, sleeping}, e)
      end
   end
   // ==========================================
   // scenarios
   // ==========================================
   initial begin
      void'($urandom(32'h4E84));
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc = 8'h00;
      c = 1'b0;
      power_down_flag = 1'b1;
      timeout_flag = 1'b1;
      rd(STATUS_ADDR, st());
      rd(ACC_ADDR, acc);
      // random operands, both destinations, carry fed forward
      for (int i = 0; i < 8; i++) begin
         f = 7'($urandom());
         v = 8'($urandom());
         wr({1'b0, f}, v);
         res = {v[6:0], c};
         ex({ROT_OPCODE, i[0], f}, 8'h04, 1'b1);
         c = v[7];
         if (i[0]) v = res;
         else acc = res;
         rd({1'b0, f}, v);
         rd(ACC_ADDR, acc);
         rd(STATUS_ADDR, st());
      end
      // near misses of the opcode change nothing
      ex({6'h0C, 1'b1, f}, 8'h02, 1'b1);
      ex({6'h2D, 1'b1, f}, 8'h02, 1'b1);
      rd({1'b0, f}, v);
      ex(SLEEP_WORD, 8'h05, 1'b1);
      power_down_flag = 1'b0;
      rd(STATUS_ADDR, st());
      // offered while asleep: must be ignored
      ex({ROT_OPCODE, 1'b1, f}, 8'h00, 1'b0);
      wake();
      rd({1'b0, f}, v);
      wr(CTRL_ADDR, 8'h01);
      repeat (40) @(posedge ref_clk);
      ex(SLEEP_WORD, 8'h05, 1'b1);
      rd(WDOG_ADDR, 8'h00);
      // prescaler restarted from zero at the sleep, four edges before the read samples it
      rd(PRESC_ADDR, 8'h03);
      wake();
      res = {v[6:0], c};
      ex({ROT_OPCODE, 1'b0, f}, 8'h04, 1'b1);
      c = v[7];
      rd(ACC_ADDR, res);
      rd(STATUS_ADDR, st());
      // 256 ticks of four cycles later the watchdog ends this sleep
      ex(SLEEP_WORD, 8'h05, 1'b1);
      q.push_back(8'h00);
      repeat (1030) @(posedge ref_clk);
      timeout_flag = 1'b0;
      rd(STATUS_ADDR, st());
      repeat (2) @(posedge ref_clk);
      // every note must have met its result
      `CHK(q.size(), 0)
      conclude();
   end
endmodule : tb_top
`default_nettype wire
